// >>> fsr_pkg.sv
// Purpose: shared constants and types of the flash sequencer
// Assumes: 20 MHz system clock
// Notes:   times in ns, cycle counts derived
package fsr_pkg;
  // ----------------------------------------
  // opcodes
  // ----------------------------------------
  localparam logic [7:0] NO_OP_CMD             = 8'h00;
  localparam logic [7:0] PAGE_PROGRAM_CMD      = 8'h02;
  localparam logic [7:0] WRITE_DISABLE_CMD     = 8'h04;
  localparam logic [7:0] STATUS_READ_CMD       = 8'h05;
  localparam logic [7:0] WRITE_ENABLE_CMD      = 8'h06;
  localparam logic [7:0] SECTOR_ERASE_CMD      = 8'h20;
  localparam logic [7:0] SECURITY_REG_READ_CMD = 8'h2b;
  localparam logic [7:0] RESUME_CMD            = 8'h30;
  localparam logic [7:0] PARAM_TABLE_READ_CMD  = 8'h5a;
  localparam logic [7:0] RESET_ARM_CMD         = 8'h66;
  localparam logic [7:0] RESET_CMD             = 8'h99;
  localparam logic [7:0] SIGNATURE_READ_CMD    = 8'hab;
  localparam logic [7:0] SUSPEND_CMD           = 8'hb0;
  // ----------------------------------------
  // link framing, bits per phase end
  // ----------------------------------------
  localparam logic [5:0] OPCODE_END = 6'h08;
  localparam logic [5:0] ADDR_END   = 6'h20;
  localparam logic [5:0] DUMMY_END  = 6'h28;
  // ----------------------------------------
  // timing
  // ----------------------------------------
  localparam int SYS_CLK_NS   = 50;
  localparam int PROGRAM_NS   = 100000;
  localparam int ERASE_NS     = 200000;
  localparam int PROG_SUSP_NS = 20000;
  localparam int ERASE_SUSP_NS = 25000;
  localparam int RECOV_PROG_NS = 80000;
  localparam int RECOV_OTHER_NS = 30000;
  localparam logic [11:0] PROGRAM_CYC    = 12'(PROGRAM_NS / SYS_CLK_NS);
  localparam logic [11:0] ERASE_CYC      = 12'(ERASE_NS / SYS_CLK_NS);
  localparam logic [11:0] PROG_SUSP_CYC  = 12'(PROG_SUSP_NS / SYS_CLK_NS);
  localparam logic [11:0] ERASE_SUSP_CYC = 12'(ERASE_SUSP_NS / SYS_CLK_NS);
  localparam logic [11:0] RECOV_PROG_CYC = 12'(RECOV_PROG_NS / SYS_CLK_NS);
  localparam logic [11:0] RECOV_OTHER_CYC = 12'(RECOV_OTHER_NS / SYS_CLK_NS);
  // ----------------------------------------
  // parameter table header
  // ----------------------------------------
  localparam logic [31:0] PT_SIGNATURE = 32'h50444653;
  localparam logic [7:0]  PT_MINOR     = 8'h00;
  localparam logic [7:0]  PT_MAJOR     = 8'h01;
  localparam logic [7:0]  PT_NHDR      = 8'h01;
  localparam logic [7:0]  PT_UNUSED    = 8'hff;
  localparam logic [7:0]  HDR0_ID      = 8'h00;
  localparam logic [7:0]  HDR0_LEN     = 8'h09;
  localparam logic [23:0] HDR0_PTR     = 24'h000030;
  localparam logic [7:0]  HDR1_ID      = 8'h5e; // arbitrary maker byte
  localparam logic [7:0]  HDR1_LEN     = 8'h04;
  localparam logic [23:0] HDR1_PTR     = 24'h000060;
  // ----------------------------------------
  // types
  // ----------------------------------------
  typedef struct packed {
    logic [7:0]  op;
    logic [23:0] addr;
  } fsr_cmd_type;
  typedef enum logic [2:0] {
    S_IDLE = 3'h0, S_PROG = 3'h1, S_SUSPWAIT = 3'h3, S_PSUS = 3'h2,
    S_ERASE = 3'h6, S_ESUS = 3'h7, S_EPROG = 3'h5, S_RECOV = 3'h4
  } fsr_seq_type;
  typedef struct packed {
    logic fresh;
    logic so;
    logic so_oe;
  } fsr_frame_type;
  localparam fsr_frame_type FRAME_IDLE = 3'h4;
endpackage

// >>> fsr_link.sv
// Purpose: serial link front end on the host's clock
// Assumes: opcode sampled on rising edges; quad flag static around frames
// Notes:   commands leave by a toggle, word held until the next one
`timescale 1ns/1ps
module fsr_link (
  input  wire logic            i_sclk,
  input  wire logic            i_resetn,
  input  wire logic            i_cs_n,
  input  wire logic [3:0]      i_sio,
  input  wire logic            i_quad_mode,
  output logic                 o_so,
  output logic                 o_so_oe,
  output fsr_pkg::fsr_cmd_type o_cmd,
  output logic                 o_cmd_tgl
);
  typedef struct packed {
    logic                 quad_s1;
    logic                 quad_s2;
    logic [5:0]           cnt;
    logic [31:0]          sh;
    logic [7:0]           op;
    logic [23:0]          addr;
    logic                 out_on;
    logic [2:0]           obit;
    logic [23:0]          rd;
    fsr_pkg::fsr_cmd_type cmd;
    logic                 tgl;
  } fsr_link_type;
  fsr_link_type          s_reg;
  fsr_link_type          s_next;
  fsr_pkg::fsr_frame_type f_reg;
  fsr_pkg::fsr_frame_type f_next;
  logic [5:0]            cnt_now;
  logic [31:0]           sh_now;
  logic                  step;
  logic [7:0]            byte_now;

  function automatic logic [7:0] pt_byte(input logic [23:0] a);
    case (a)
      24'h000000: pt_byte = fsr_pkg::PT_SIGNATURE[7:0];
      24'h000001: pt_byte = fsr_pkg::PT_SIGNATURE[15:8];
      24'h000002: pt_byte = fsr_pkg::PT_SIGNATURE[23:16];
      24'h000003: pt_byte = fsr_pkg::PT_SIGNATURE[31:24];
      24'h000004: pt_byte = fsr_pkg::PT_MINOR;
      24'h000005: pt_byte = fsr_pkg::PT_MAJOR;
      24'h000006: pt_byte = fsr_pkg::PT_NHDR;
      24'h000008: pt_byte = fsr_pkg::HDR0_ID;
      24'h000009: pt_byte = fsr_pkg::PT_MINOR;
      24'h00000a: pt_byte = fsr_pkg::PT_MAJOR;
      24'h00000b: pt_byte = fsr_pkg::HDR0_LEN;
      24'h00000c: pt_byte = fsr_pkg::HDR0_PTR[7:0];
      24'h00000d: pt_byte = fsr_pkg::HDR0_PTR[15:8];
      24'h00000e: pt_byte = fsr_pkg::HDR0_PTR[23:16];
      24'h000010: pt_byte = fsr_pkg::HDR1_ID;
      24'h000011: pt_byte = fsr_pkg::PT_MINOR;
      24'h000012: pt_byte = fsr_pkg::PT_MAJOR;
      24'h000013: pt_byte = fsr_pkg::HDR1_LEN;
      24'h000014: pt_byte = fsr_pkg::HDR1_PTR[7:0];
      24'h000015: pt_byte = fsr_pkg::HDR1_PTR[15:8];
      24'h000016: pt_byte = fsr_pkg::HDR1_PTR[23:16];
      default:    pt_byte = fsr_pkg::PT_UNUSED;
    endcase
  endfunction

  always_comb
  begin
    s_next = s_reg;
    f_next = f_reg;
    f_next.fresh = 1'b0;
    s_next.quad_s1 = i_quad_mode;
    s_next.quad_s2 = s_reg.quad_s1;
    // quad takes four lines per edge, single ignores the upper lines
    cnt_now = f_reg.fresh ? 6'h00 : s_reg.cnt;
    sh_now = s_reg.quad_s2 ? {s_reg.sh[27:0], i_sio} : {s_reg.sh[30:0], i_sio[0]};
    step = s_reg.out_on & ~f_reg.fresh;
    byte_now = pt_byte(s_reg.rd);
    if (f_reg.fresh)
    begin
      s_next.out_on = 1'b0;
    end
    if (!step && cnt_now < fsr_pkg::DUMMY_END)
    begin
      s_next.sh = sh_now;
      s_next.cnt = cnt_now + (s_reg.quad_s2 ? 6'h04 : 6'h01);
      if (s_next.cnt == fsr_pkg::OPCODE_END)
      begin
        s_next.op = sh_now[7:0];
        if (sh_now[7:0] != fsr_pkg::PAGE_PROGRAM_CMD &&
            sh_now[7:0] != fsr_pkg::SECTOR_ERASE_CMD)
        begin
          s_next.cmd = '{op: sh_now[7:0], addr: 24'h000000};
          s_next.tgl = ~s_reg.tgl;
        end
      end
      if (s_next.cnt == fsr_pkg::ADDR_END)
      begin
        s_next.addr = sh_now[23:0];
        if (s_reg.op == fsr_pkg::PAGE_PROGRAM_CMD || s_reg.op == fsr_pkg::SECTOR_ERASE_CMD)
        begin
          s_next.cmd = '{op: s_reg.op, addr: sh_now[23:0]};
          s_next.tgl = ~s_reg.tgl;
        end
      end
      if (s_next.cnt == fsr_pkg::DUMMY_END && s_reg.op == fsr_pkg::PARAM_TABLE_READ_CMD)
      begin
        s_next.out_on = 1'b1;
        s_next.rd = s_reg.addr;
        s_next.obit = 3'h7;
      end
    end
    if (step)
    begin
      f_next.so = byte_now[s_reg.obit];
      f_next.so_oe = 1'b1;
      s_next.obit = s_reg.obit - 3'h1;
      if (s_reg.obit == 3'h0)
      begin
        s_next.rd = s_reg.rd + 24'h000001;
      end
    end
  end

  always_ff @(posedge i_sclk or negedge i_resetn)
  begin
    if (!i_resetn)
      s_reg <= '0;
    else
      s_reg <= s_next;
  end

  // chip select high drops the driver at once, with no clock edge needed
  always_ff @(posedge i_sclk or posedge i_cs_n or negedge i_resetn)
  begin
    if (!i_resetn || i_cs_n)
      f_reg <= fsr_pkg::FRAME_IDLE;
    else
      f_reg <= f_next;
  end

  assign o_so      = f_reg.so;
  assign o_so_oe   = f_reg.so_oe;
  assign o_cmd     = s_reg.cmd;
  assign o_cmd_tgl = s_reg.tgl;
endmodule

// >>> fsr_core.sv
// Purpose: suspend, resume and software reset sequencing of a serial flash
// Assumes: host link on its own clock; commands cross by toggle
// Notes:   array contents are not modelled, only sequencing and status
// ----------------------------------------
// ----------------------------------------
`timescale 1ns/1ps
module fsr_core (
  input  wire logic       I_SYS_CLK,
  input  wire logic       I_RESETN,
  input  wire logic       I_SCLK,
  input  wire logic       I_CS_N,
  input  wire logic [3:0] I_SIO,
  input  wire logic       I_QUAD_MODE,
  input  wire logic       I_PERF_MODE,
  output logic            O_SO,
  output logic            O_SO_OE,
  output logic            O_WRITE_ENABLE_LATCH,
  output logic            O_WRITE_IN_PROGRESS,
  output logic            O_PROGRAM_SUSPENDED_FLAG,
  output logic            O_ERASE_SUSPENDED_FLAG,
  output logic            O_RESET_ARMED,
  output logic            O_RECOVERING,
  output logic            O_ABORTED
);
  // ----------------------------------------
  // state
  // ----------------------------------------
  typedef struct packed {
    logic                tgl_s1;
    logic                tgl_s2;
    logic                tgl_s3;
    logic                perf_s1;
    logic                perf_s2;
    fsr_pkg::fsr_seq_type st;
    logic [11:0]         cnt;
    logic [11:0]         rem;
    logic [11:0]         sector;
    logic                was_erase;
    logic                write_enable_latch;
    logic                write_in_progress;
    logic                psus;
    logic                esus;
    logic                arm;
    logic                recov;
    logic                aborted;
  } fsr_sys_type;

  fsr_sys_type          s_reg;
  fsr_sys_type          s_next;
  fsr_pkg::fsr_cmd_type link_cmd;
  logic                 link_tgl;
  logic                 fire;
  logic [7:0]           op;
  logic                 busy_op;

  // ----------------------------------------
  // link domain
  // ----------------------------------------
  fsr_link u_link (
    .i_sclk      (I_SCLK),
    .i_resetn    (I_RESETN),
    .i_cs_n      (I_CS_N),
    .i_sio       (I_SIO),
    .i_quad_mode (I_QUAD_MODE),
    .o_so        (O_SO),
    .o_so_oe     (O_SO_OE),
    .o_cmd       (link_cmd),
    .o_cmd_tgl   (link_tgl)
  );

  // the word is stable long before the toggle is seen here, so it is read
  // directly once the synchronised toggle changes
  assign fire = s_reg.tgl_s2 ^ s_reg.tgl_s3;
  assign op = link_cmd.op;
  assign busy_op = (s_reg.st == fsr_pkg::S_PROG) || (s_reg.st == fsr_pkg::S_ERASE) ||
                   (s_reg.st == fsr_pkg::S_EPROG) || (s_reg.st == fsr_pkg::S_SUSPWAIT);

  // ----------------------------------------
  // sequencer
  // ----------------------------------------
  always_comb
  begin
    s_next = s_reg;
    s_next.tgl_s1 = link_tgl;
    s_next.tgl_s2 = s_reg.tgl_s1;
    s_next.tgl_s3 = s_reg.tgl_s2;
    s_next.perf_s1 = I_PERF_MODE;
    s_next.perf_s2 = s_reg.perf_s1;
    if (s_reg.cnt != 12'h000)
    begin
      s_next.cnt = s_reg.cnt - 12'h001;
    end
    // timed completions
    case (s_reg.st)
      fsr_pkg::S_PROG, fsr_pkg::S_ERASE:
      begin
        if (s_reg.cnt == 12'h000)
        begin
          s_next.st = fsr_pkg::S_IDLE;
          s_next.write_enable_latch = 1'b0;
          s_next.write_in_progress = 1'b0;
        end
      end
      fsr_pkg::S_EPROG:
      begin
        if (s_reg.cnt == 12'h000)
        begin
          s_next.st = fsr_pkg::S_ESUS;
          s_next.write_enable_latch = 1'b0;
          s_next.write_in_progress = 1'b0;
        end
      end
      fsr_pkg::S_SUSPWAIT:
      begin
        if (s_reg.cnt == 12'h000)
        begin
          s_next.st = s_reg.was_erase ? fsr_pkg::S_ESUS : fsr_pkg::S_PSUS;
          s_next.esus = s_reg.was_erase;
          s_next.psus = ~s_reg.was_erase;
          s_next.write_enable_latch = 1'b0;
          s_next.write_in_progress = 1'b0;
        end
      end
      fsr_pkg::S_RECOV:
      begin
        if (s_reg.cnt == 12'h000)
        begin
          s_next.st = fsr_pkg::S_IDLE;
        end
      end
      default:
      begin
      end
    endcase
    // commands; none are taken while recovering from a reset
    if (fire && s_reg.st != fsr_pkg::S_RECOV)
    begin
      // any command other than reset arm drops a pending arm
      s_next.arm = (op == fsr_pkg::RESET_ARM_CMD);
      if (op == fsr_pkg::RESET_CMD && s_reg.arm)
      begin
        s_next.st = fsr_pkg::S_RECOV;
        s_next.cnt = ((s_reg.st == fsr_pkg::S_PROG) || (s_reg.st == fsr_pkg::S_EPROG)) ?
                     fsr_pkg::RECOV_PROG_CYC - 12'h001 :
                     fsr_pkg::RECOV_OTHER_CYC - 12'h001;
        s_next.aborted = busy_op;
        s_next.write_enable_latch = 1'b0;
        s_next.write_in_progress = 1'b0;
        s_next.psus = 1'b0;
        s_next.esus = 1'b0;
        s_next.rem = 12'h000;
        s_next.sector = 12'h000;
        s_next.was_erase = 1'b0;
      end
      else if (op == fsr_pkg::WRITE_DISABLE_CMD &&
               (s_reg.st == fsr_pkg::S_IDLE || s_reg.st == fsr_pkg::S_PSUS ||
                s_reg.st == fsr_pkg::S_ESUS || s_reg.st == fsr_pkg::S_SUSPWAIT))
      begin
        s_next.write_enable_latch = 1'b0;
      end
      else
      begin
        case (s_reg.st)
          fsr_pkg::S_IDLE:
          begin
            if (op == fsr_pkg::WRITE_ENABLE_CMD)
            begin
              s_next.write_enable_latch = 1'b1;
            end
            else if (op == fsr_pkg::PAGE_PROGRAM_CMD && s_reg.write_enable_latch)
            begin
              s_next.st = fsr_pkg::S_PROG;
              s_next.cnt = fsr_pkg::PROGRAM_CYC - 12'h001;
              s_next.write_in_progress = 1'b1;
            end
            else if (op == fsr_pkg::SECTOR_ERASE_CMD && s_reg.write_enable_latch)
            begin
              s_next.st = fsr_pkg::S_ERASE;
              s_next.cnt = fsr_pkg::ERASE_CYC - 12'h001;
              s_next.write_in_progress = 1'b1;
              s_next.sector = link_cmd.addr[23:12];
            end
          end
          fsr_pkg::S_PROG, fsr_pkg::S_ERASE:
          begin
            if (op == fsr_pkg::SUSPEND_CMD && s_reg.cnt != 12'h000)
            begin
              s_next.st = fsr_pkg::S_SUSPWAIT;
              s_next.rem = s_reg.cnt;
              s_next.was_erase = (s_reg.st == fsr_pkg::S_ERASE);
              s_next.cnt = (s_reg.st == fsr_pkg::S_ERASE) ?
                           fsr_pkg::ERASE_SUSP_CYC - 12'h001 :
                           fsr_pkg::PROG_SUSP_CYC - 12'h001;
            end
          end
          fsr_pkg::S_PSUS:
          begin
            if (op == fsr_pkg::RESUME_CMD && !s_reg.perf_s2)
            begin
              s_next.st = fsr_pkg::S_PROG;
              s_next.cnt = s_reg.rem;
              s_next.write_enable_latch = 1'b1;
              s_next.write_in_progress = 1'b1;
              s_next.psus = 1'b0;
            end
          end
          fsr_pkg::S_ESUS:
          begin
            if (op == fsr_pkg::WRITE_ENABLE_CMD)
            begin
              s_next.write_enable_latch = 1'b1;
            end
            // the program may not touch the sector whose erase is parked
            else if (op == fsr_pkg::PAGE_PROGRAM_CMD && s_reg.write_enable_latch &&
                     link_cmd.addr[23:12] != s_reg.sector)
            begin
              s_next.st = fsr_pkg::S_EPROG;
              s_next.cnt = fsr_pkg::PROGRAM_CYC - 12'h001;
              s_next.write_enable_latch = 1'b1;
              s_next.write_in_progress = 1'b1;
            end
            else if (op == fsr_pkg::RESUME_CMD && !s_reg.perf_s2)
            begin
              s_next.st = fsr_pkg::S_ERASE;
              s_next.cnt = s_reg.rem;
              s_next.write_enable_latch = 1'b1;
              s_next.write_in_progress = 1'b1;
              s_next.esus = 1'b0;
            end
          end
          // suspend and resume are both refused while this program runs
          fsr_pkg::S_EPROG:
          begin
          end
          default:
          begin
          end
        endcase
      end
    end
    s_next.recov = (s_next.st == fsr_pkg::S_RECOV);
  end

  always_ff @(posedge I_SYS_CLK or negedge I_RESETN)
  begin
    if (!I_RESETN)
      s_reg <= '0;
    else
      s_reg <= s_next;
  end

  assign O_WRITE_ENABLE_LATCH     = s_reg.write_enable_latch;
  assign O_WRITE_IN_PROGRESS      = s_reg.write_in_progress;
  assign O_PROGRAM_SUSPENDED_FLAG = s_reg.psus;
  assign O_ERASE_SUSPENDED_FLAG   = s_reg.esus;
  assign O_RESET_ARMED            = s_reg.arm;
  assign O_RECOVERING             = s_reg.recov;
  assign O_ABORTED                = s_reg.aborted;

  // ----------------------------------------
  // checks
  // ----------------------------------------
  default clocking cb @(posedge I_SYS_CLK);
  endclocking
  default disable iff (!I_RESETN);

  resume_sets_flags_a: assert property (
    fire && op == fsr_pkg::RESUME_CMD && s_reg.st == fsr_pkg::S_PSUS && !s_reg.perf_s2
    |=> s_reg.write_enable_latch && s_reg.write_in_progress && !s_reg.psus && s_reg.st == fsr_pkg::S_PROG)
    else $error("resume did not set latch and busy");

  resume_continue_a: assert property (
    fire && op == fsr_pkg::RESUME_CMD && s_reg.st == fsr_pkg::S_ESUS && !s_reg.perf_s2
    && !(op == fsr_pkg::RESET_CMD)
    |=> s_reg.st == fsr_pkg::S_ERASE && s_reg.cnt == $past(s_reg.rem) && !s_reg.esus)
    else $error("erase did not continue from its remainder");

  perf_ignore_a: assert property (
    fire && op == fsr_pkg::RESUME_CMD && s_reg.perf_s2 &&
    (s_reg.st == fsr_pkg::S_PSUS || s_reg.st == fsr_pkg::S_ESUS)
    |=> $stable(s_reg.st) && $stable(s_reg.psus) && $stable(s_reg.esus))
    else $error("resume taken in performance enhance mode");

  eprog_flags_a: assert property (
    s_reg.st == fsr_pkg::S_EPROG |-> s_reg.write_enable_latch && s_reg.write_in_progress && s_reg.esus)
    else $error("latch or busy low during program in suspend");

  eprog_done_a: assert property (
    s_reg.st == fsr_pkg::S_EPROG && s_reg.cnt == 12'h000 && !fire
    |=> s_reg.st == fsr_pkg::S_ESUS && !s_reg.write_enable_latch && !s_reg.write_in_progress
    && s_reg.esus)
    else $error("program in suspend did not finish cleanly");

  eprog_nosusp_a: assert property (
    fire && (op == fsr_pkg::SUSPEND_CMD || op == fsr_pkg::RESUME_CMD) &&
    s_reg.st == fsr_pkg::S_EPROG
    |=> s_reg.st == fsr_pkg::S_EPROG || s_reg.st == fsr_pkg::S_ESUS)
    else $error("program in suspend was suspended or resumed");

  sector_guard_a: assert property (
    fire && op == fsr_pkg::PAGE_PROGRAM_CMD && s_reg.st == fsr_pkg::S_ESUS &&
    link_cmd.addr[23:12] == s_reg.sector |=> s_reg.st == fsr_pkg::S_ESUS
    && !s_reg.write_in_progress)
    else $error("program entered the suspended sector");

  noop_cancel_a: assert property (
    fire && op == fsr_pkg::NO_OP_CMD && s_reg.st == fsr_pkg::S_IDLE
    |=> !s_reg.arm && $stable(s_reg.write_enable_latch) && s_reg.st == fsr_pkg::S_IDLE)
    else $error("no-op did more than cancel the arm");

  reset_needs_arm_a: assert property (
    fire && op == fsr_pkg::RESET_CMD && !s_reg.arm && s_reg.st != fsr_pkg::S_RECOV
    |=> s_reg.st != fsr_pkg::S_RECOV)
    else $error("reset acted without a preceding arm");

  sw_reset_a: assert property (
    fire && op == fsr_pkg::RESET_CMD && s_reg.arm && s_reg.st != fsr_pkg::S_RECOV
    |=> s_reg.recov && !s_reg.write_enable_latch && !s_reg.write_in_progress && !s_reg.psus && !s_reg.esus
    && !s_reg.arm && s_reg.aborted == $past(busy_op))
    else $error("software reset left state behind");

  recov_len_a: assert property (
    s_reg.st == fsr_pkg::S_RECOV && $past(s_reg.st) == fsr_pkg::S_PROG
    |-> s_reg.cnt == fsr_pkg::RECOV_PROG_CYC - 12'h001)
    else $error("wrong recovery length after aborted program");

  susp_free_a: assert property (
    fire && op == fsr_pkg::WRITE_DISABLE_CMD && s_reg.st == fsr_pkg::S_SUSPWAIT
    |=> !s_reg.write_enable_latch)
    else $error("disable-write not taken during suspend latency");

  cover_reset_c: cover property (
    fire && op == fsr_pkg::RESET_CMD && s_reg.arm && busy_op);
  cover_eprog_c: cover property (
    s_reg.st == fsr_pkg::S_ESUS ##1 s_reg.st == fsr_pkg::S_EPROG);
  cover_resume_c: cover property (
    s_reg.st == fsr_pkg::S_PSUS ##1 s_reg.st == fsr_pkg::S_PROG);
  cover_table_c: cover property ($rose(O_SO_OE));
endmodule

// >>> fsr_host.sv
// Purpose: host link model driving frames into the sequencer
// Assumes: link clock also ticks outside frames, with chip select held high
// Notes:   released data lines show the inverse of the last bits
`timescale 1ns/1ps
module fsr_host (
  output logic       o_sclk,
  output logic       o_cs_n,
  output logic [3:0] o_sio,
  input  wire logic  i_so,
  input  wire logic  i_quad
);
  logic [191:0] rx;
  task automatic tick();
    #62.5 o_sclk = 1'b1;
    #62.5 o_sclk = 1'b0;
  endtask
  task automatic frame(input logic [39:0] w, input int ne, input int nr);
    o_cs_n = 1'b0;
    repeat (ne)
    begin
      o_sio = i_quad ? w[39:36] : {~w[38:36], w[39]};
      w = i_quad ? w << 4 : w << 1;
      tick();
    end
    // the device moves a bit on each rise, so each bit is taken after its edge
    repeat (nr)
    begin
      tick();
      rx = {rx[190:0], i_so};
    end
    #62.5 o_cs_n = 1'b1;
    o_sio = ~o_sio;
  endtask
  initial {o_sclk, o_cs_n, o_sio, rx} = {2'b01, 4'h0, 192'h0};
endmodule

// >>> fsr_core_test.sv
// Purpose: self-checking bench of the sequencer
// Assumes: host model drives the link
// Notes:   full-length counts kept, run stays short
`timescale 1ns/1ps
module fsr_core_test;
  logic clk = 1'b0, rstn = 1'b0, quad = 1'b0, perf = 1'b0;
  logic sclk, csn, so, oe, write_enable_latch, write_in_progress, psus, esus, arm, rec, abt;
  logic [3:0] sio;
  wire [3:0] fl = {write_enable_latch, write_in_progress, psus, esus};
  int err_total = 0, total_checks = 0, cyc = 0;
  always #25 clk = ~clk;
  fsr_host host (.o_sclk(sclk), .o_cs_n(csn), .o_sio(sio), .i_so(so), .i_quad(quad));
  fsr_core dut_u (.I_SYS_CLK(clk), .I_RESETN(rstn), .I_SCLK(sclk), .I_CS_N(csn),
    .I_SIO(sio), .I_QUAD_MODE(quad), .I_PERF_MODE(perf), .O_SO(so), .O_SO_OE(oe),
    .O_WRITE_ENABLE_LATCH(write_enable_latch), .O_WRITE_IN_PROGRESS(write_in_progress),
    .O_PROGRAM_SUSPENDED_FLAG(psus), .O_ERASE_SUSPENDED_FLAG(esus),
    .O_RESET_ARMED(arm), .O_RECOVERING(rec), .O_ABORTED(abt));
  task automatic chk(input string n, input logic [191:0] e, input logic [191:0] g);
    total_checks++;
    if (g !== e)
    begin
      err_total++;
      $display("mismatch %s exp %h got %h", n, e, g);
    end
  endtask
  task automatic cmd(input logic [31:0] w, input int ne);
    host.frame({w, 8'h00}, ne, 0);
    repeat (8) @(negedge clk);
  endtask
  task automatic op(input logic [7:0] c);
    cmd({c, 24'h0}, quad ? 2 : 8);
  endtask
  task automatic close_out();
    $display("checks %0d mismatches %0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  // guard against a hang; tests need about 9000 cycles
  always @(posedge clk)
  begin
    cyc <= cyc + 1;
    if (cyc == 20000)
    begin
      err_total++;
      close_out();
    end
  end
  initial
  begin
    repeat (12) @(negedge clk);
    rstn = 1'b1;
    repeat (3) host.tick();
    host.frame({8'h5a, 32'h0}, 40, 192);
    chk("table", {64'h53464450000101ff, 64'h00000109300000ff, fsr_pkg::HDR1_ID,
      56'h000104600000ff}, host.rx);
    repeat (4) @(negedge clk);
    host.frame({8'h5a, 32'h0}, 40, 3);
    #1 chk("so_oe", 0, oe);
    repeat (8) @(negedge clk);
    $display("test table done");
    op(8'h66);
    chk("armed", 1, arm);
    op(8'h00);
    chk("armed", 0, arm);
    op(8'h99);
    chk("recovering", 0, rec);
    quad = 1'b1;
    repeat (3) host.tick();
    op(8'h66);
    op(8'h99);
    chk("recovering", 1, rec);
    quad = 1'b0;
    repeat (3) host.tick();
    repeat (fsr_pkg::RECOV_OTHER_CYC) @(negedge clk);
    chk("recovering", 0, rec);
    $display("test reset done");
    op(8'h06);
    cmd({8'h02, 24'h003000}, 32);
    op(8'hb0);
    repeat (fsr_pkg::PROG_SUSP_CYC) @(negedge clk);
    chk("flags", 4'h2, fl);
    op(8'h30);
    chk("flags", 4'hc, fl);
    repeat (8) @(negedge clk);
    op(8'hb0);
    repeat (fsr_pkg::PROG_SUSP_CYC) @(negedge clk);
    chk("flags", 4'h2, fl);
    op(8'h66);
    op(8'h99);
    chk("aborted", 0, abt);
    chk("flags", 4'h0, fl);
    repeat (fsr_pkg::RECOV_OTHER_CYC) @(negedge clk);
    $display("test program suspend done");
    op(8'h06);
    cmd({8'h20, 24'h001000}, 32);
    chk("busy", 1, write_in_progress);
    op(8'hb0);
    op(8'h04);
    chk("flags", 4'h4, fl);
    repeat (fsr_pkg::ERASE_SUSP_CYC) @(negedge clk);
    op(8'h05);
    chk("flags", 4'h1, fl);
    op(8'h06);
    cmd({8'h02, 24'h001abc}, 32);
    chk("flags", 4'h9, fl);
    op(8'h06);
    cmd({8'h02, 24'h002000}, 32);
    chk("flags", 4'hd, fl);
    op(8'h30);
    chk("flags", 4'hd, fl);
    repeat (fsr_pkg::PROGRAM_CYC) @(negedge clk);
    chk("flags", 4'h1, fl);
    perf = 1'b1;
    op(8'h30);
    chk("flags", 4'h1, fl);
    perf = 1'b0;
    op(8'h30);
    chk("flags", 4'hc, fl);
    op(8'h66);
    op(8'h99);
    chk("aborted", 1, abt);
    chk("flags", 4'h0, fl);
    repeat (fsr_pkg::RECOV_OTHER_CYC) @(negedge clk);
    op(8'h06);
    cmd({8'h02, 24'h000000}, 32);
    op(8'h66);
    op(8'h99);
    repeat (fsr_pkg::RECOV_OTHER_CYC) @(negedge clk);
    chk("recovering", 1, rec);
    repeat (fsr_pkg::RECOV_PROG_CYC - fsr_pkg::RECOV_OTHER_CYC) @(negedge clk);
    chk("recovering", 0, rec);
    $display("test suspend done");
    close_out();
  end
endmodule
